//--- iecb_pkg.sv
// Package with the register map, field layouts and carriers of the event clear bank.
`default_nettype none
package iecb_pkg;

    // ----------------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_GROUPS = 8;

    // ----------------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------------
    localparam logic [11:0] REF_AB_EVENT_CLEAR = 12'hA07;
    localparam logic [11:0] REF_CD_EVENT_CLEAR = 12'hA08;
    localparam logic [11:0] LOOP0_LOCK_EVENT_CLEAR = 12'hA09;
    localparam logic [11:0] LOOP0_MODE_EVENT_CLEAR = 12'hA0A;
    localparam logic [11:0] LOOP0_MISC_EVENT_CLEAR = 12'hA0B;
    localparam logic [11:0] LOOP1_LOCK_EVENT_CLEAR = 12'hA0C;
    localparam logic [11:0] LOOP1_MODE_EVENT_CLEAR = 12'hA0D;
    localparam logic [11:0] LOOP1_MISC_EVENT_CLEAR = 12'hA0E;
    localparam logic [11:0] EVENT_MONITOR_BASE = 12'hD08;
    localparam logic [11:0] IRQ_MASK_BASE = 12'hD20;
    localparam logic [11:0] IRQ_STATUS = 12'hD30;

    // ----------------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0] REF_CLEAR_VALID_BITS = 8'h77;
    localparam logic [7:0] FULL_BYTE = 8'hFF;
    localparam logic [7:0] MONITOR_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ----------------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } iecb_bus_req_t;

    typedef logic [7:0] iecb_group_t;
    typedef iecb_group_t [7:0] iecb_bank_t;

endpackage
`default_nettype wire

//--- iecb_top.sv
// Interrupt event clear bank: latched event monitor with write-one-to-clear registers.
//
// Function
// R1: Ref clear reg bits 0-2 cancel input a fault/cleared/validated; 4-6 input b.
// R2: Second ref clear reg bits 0-2 input c, bits 4-6 input d.
// R3: Bits 3 and 7 of both reference clear registers do nothing.
// R4: Loop 0 lock clear bits 0-3: phase lock, phase unlock, freq lock, freq unlock.
// R5: Loop 0 lock clear bits 4-7: slew enter/leave, clamp enter/leave.
// R6: Loop 0 mode clear bits 0-3: reference a to d activated.
// R7: Loop 0 mode clear bits 4-7: history, holdover, free run, switching.
// R8: Loop 0 misc clear bits 0-3: analog loop cal start/end, lock, unlock.
// R9: Loop 0 misc clear bits 4-7: dist sync, demap clamp/unclamp, phase step.
// R10: Loop 1 lock clear register has loop 0 lock layout.
// R11: Loop 1 mode clear register has loop 0 mode layout.
// R12: Loop 1 misc clear register has loop 0 misc layout.
// R13: A one written clears the matching latched monitor bit, withdrawing the request.
// R14: Clear bits self-return to zero; no release write is needed.
// R15: Writing zero leaves the matching monitor bit unchanged.
// R16: An event in the same cycle as its clear keeps the monitor bit set.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module iecb_top
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output var logic [7:0] rdata_o,
    // Event inputs, one pulse per event, same layout as the clear registers
    input wire iecb_pkg::iecb_bank_t event_i,
    // Latched monitor and interrupt
    output var iecb_pkg::iecb_bank_t monitor_o,
    output var logic irq_o
);

    // ----------------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------------
    function automatic logic [7:0] group_mask(input logic [2:0] idx);
        // Reference groups carry only six events; bits 3 and 7 stay inert.
        group_mask = (idx < 3'd2) ? iecb_pkg::REF_CLEAR_VALID_BITS : iecb_pkg::FULL_BYTE; // [R3]
    endfunction

    function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
        in_bank = (a >= base) && (a < base + 12'h008);
    endfunction

    iecb_pkg::iecb_bus_req_t req;
    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    wire logic clr_hit;
    wire logic mon_hit;
    wire logic mask_hit;
    wire logic stat_hit;
    wire logic [2:0] clr_idx;
    wire logic [2:0] mon_idx;
    wire logic [2:0] mask_idx;
    assign clr_hit = in_bank(req.addr, iecb_pkg::REF_AB_EVENT_CLEAR);
    assign mon_hit = in_bank(req.addr, iecb_pkg::EVENT_MONITOR_BASE);
    assign mask_hit = in_bank(req.addr, iecb_pkg::IRQ_MASK_BASE);
    assign stat_hit = (req.addr == iecb_pkg::IRQ_STATUS);
    assign clr_idx = 3'(req.addr - iecb_pkg::REF_AB_EVENT_CLEAR);
    assign mon_idx = 3'(req.addr - iecb_pkg::EVENT_MONITOR_BASE);
    assign mask_idx = 3'(req.addr - iecb_pkg::IRQ_MASK_BASE);

    // ----------------------------------------------------------------------
    // Clear pulses
    // ----------------------------------------------------------------------
    // The clear strobe exists only in the write cycle, so nothing is held and
    // software never writes a release value.
    iecb_pkg::iecb_bank_t clr_pulse; // [R14]
    always_comb
    begin
        clr_pulse = '0;
        if (req.wr && clr_hit)
        begin
            // Bit order of every group matches the monitor layout. [R1] [R2] [R4] [R5]
            // [R6] [R7] [R8] [R9] [R10] [R11] [R12]
            clr_pulse[clr_idx] = req.wdata & group_mask(clr_idx); // [R15]
        end
    end

    // ----------------------------------------------------------------------
    // Monitor and mask
    // ----------------------------------------------------------------------
    iecb_pkg::iecb_bank_t next_monitor;
    iecb_pkg::iecb_bank_t mask;
    iecb_pkg::iecb_bank_t next_mask;
    always_comb
    begin
        // Reserved reference bits are never stored, so they can never raise the line.
        next_mask = mask;
        if (req.wr && mask_hit)
        begin
            next_mask[mask_idx] = req.wdata & group_mask(mask_idx);
        end
    end

    always_comb
    begin
        for (int g = 0; g < iecb_pkg::NUM_GROUPS; g++)
        begin
            // Set wins over clear so a recurring event is never lost.
            next_monitor[g] = (monitor_o[g] & ~clr_pulse[g]) // [R13]
                            | (event_i[g] & group_mask(3'(g))); // [R16]
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            monitor_o <= {iecb_pkg::NUM_GROUPS{iecb_pkg::MONITOR_RESET}};
        end
        else
        begin
            monitor_o <= next_monitor;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mask <= {iecb_pkg::NUM_GROUPS{iecb_pkg::MASK_RESET}};
        end
        else
        begin
            mask <= next_mask;
        end
    end

    wire logic next_irq;
    // Both next values feed the interrupt so that it moves on the same edge as a
    // mask write; the registered mask alone would leave it one cycle behind.
    assign next_irq = |(next_monitor & next_mask);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= next_irq;
        end
    end

    // ----------------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------------
    // Clear registers are write only and read as zero, as do unmapped offsets.
    logic [7:0] stat_byte;
    always_comb
    begin
        for (int g = 0; g < iecb_pkg::NUM_GROUPS; g++)
        begin
            stat_byte[g] = |(monitor_o[g] & mask[g]);
        end
    end

    wire logic [7:0] next_rdata;
    assign next_rdata = !req.rd ? iecb_pkg::READ_IDLE :
                        mon_hit ? monitor_o[mon_idx] :
                        mask_hit ? mask[mask_idx] :
                        stat_hit ? stat_byte : iecb_pkg::READ_IDLE;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    sequence s_clear_ref_a_fault;
        wr_i && addr_i == iecb_pkg::REF_AB_EVENT_CLEAR && wdata_i[0] && !event_i[0][0];
    endsequence

    a_ref_a_clear: assert property ( // [R1]
        @(posedge clk_sys_i) disable iff (rst_i)
        s_clear_ref_a_fault |=> !monitor_o[0][0])
        else $error("Input a fault event not cleared.");

    a_ref_cd_clear: assert property ( // [R2]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::REF_CD_EVENT_CLEAR && wdata_i[6] && !event_i[1][6]
        |=> !monitor_o[1][6])
        else $error("Input d validated event not cleared.");

    a_ref_reserved_inert: assert property ( // [R3]
        @(posedge clk_sys_i) disable iff (rst_i)
        !monitor_o[0][3] && !monitor_o[0][7] && !monitor_o[1][3] && !monitor_o[1][7])
        else $error("Reserved reference monitor bit set.");

    a_loop0_lock_clear: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_LOCK_EVENT_CLEAR && wdata_i[3] && !event_i[2][3]
        |=> !monitor_o[2][3])
        else $error("Loop 0 frequency unlock event not cleared.");

    a_loop1_misc_clear: assert property ( // [R12]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP1_MISC_EVENT_CLEAR && wdata_i[7] && !event_i[7][7]
        |=> !monitor_o[7][7])
        else $error("Loop 1 phase step event not cleared.");

    a_zero_keeps: assert property ( // [R15]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MODE_EVENT_CLEAR && !wdata_i[5] && monitor_o[3][5]
        |=> monitor_o[3][5])
        else $error("Monitor bit lost on zero write.");

    a_set_wins: assert property ( // [R16]
        @(posedge clk_sys_i) disable iff (rst_i)
        event_i[4][2] |=> monitor_o[4][2])
        else $error("Event lost against clear.");

    // ----------------------------------------------------------------------
    // Checks on the remaining clear fields
    // ----------------------------------------------------------------------
    a_ref_b_clear: assert property ( // [R1]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::REF_AB_EVENT_CLEAR && wdata_i[6] && !event_i[0][6]
        |=> !monitor_o[0][6])
        else $error("Input b validated event not cleared.");

    a_ref_c_clear: assert property ( // [R2]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::REF_CD_EVENT_CLEAR && wdata_i[1] && !event_i[1][1]
        |=> !monitor_o[1][1])
        else $error("Input c fault removed event not cleared.");

    a_loop0_slew_clear: assert property ( // [R5]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_LOCK_EVENT_CLEAR && wdata_i[4] && !event_i[2][4]
        |=> !monitor_o[2][4])
        else $error("Loop 0 slew limit entry event not cleared.");

    a_loop0_act_clear: assert property ( // [R6]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MODE_EVENT_CLEAR && wdata_i[0] && !event_i[3][0]
        |=> !monitor_o[3][0])
        else $error("Loop 0 input a activation event not cleared.");

    a_loop0_hold_clear: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MODE_EVENT_CLEAR && wdata_i[5] && !event_i[3][5]
        |=> !monitor_o[3][5])
        else $error("Loop 0 holdover event not cleared.");

    a_analog0_cal_clear: assert property ( // [R8]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MISC_EVENT_CLEAR && wdata_i[0] && !event_i[4][0]
        |=> !monitor_o[4][0])
        else $error("Analog loop 0 calibration start event not cleared.");

    a_loop0_sync_clear: assert property ( // [R9]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MISC_EVENT_CLEAR && wdata_i[4] && !event_i[4][4]
        |=> !monitor_o[4][4])
        else $error("Loop 0 distribution sync event not cleared.");

    a_loop0_demap_clear: assert property ( // [R9]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_MISC_EVENT_CLEAR && wdata_i[5] && !event_i[4][5]
        |=> !monitor_o[4][5])
        else $error("Loop 0 demap clamp event not cleared.");

    a_loop1_lock_clear: assert property ( // [R10]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP1_LOCK_EVENT_CLEAR && wdata_i[2] && !event_i[5][2]
        |=> !monitor_o[5][2])
        else $error("Loop 1 frequency lock event not cleared.");

    a_loop1_clamp_clear: assert property ( // [R10]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP1_LOCK_EVENT_CLEAR && wdata_i[7] && !event_i[5][7]
        |=> !monitor_o[5][7])
        else $error("Loop 1 clamp exit event not cleared.");

    a_loop1_mode_clear: assert property ( // [R11]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP1_MODE_EVENT_CLEAR && wdata_i[7] && !event_i[6][7]
        |=> !monitor_o[6][7])
        else $error("Loop 1 switching event not cleared.");

    a_analog1_lock_clear: assert property ( // [R12]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP1_MISC_EVENT_CLEAR && wdata_i[2] && !event_i[7][2]
        |=> !monitor_o[7][2])
        else $error("Analog loop 1 lock event not cleared.");

    // ----------------------------------------------------------------------
    // Checks on release, neighbours and the interrupt
    // ----------------------------------------------------------------------
    // A phase lock clear of digital loop 0 with the event quiet in that cycle.
    sequence s_clear_lock0_phase;
        wr_i && addr_i == iecb_pkg::LOOP0_LOCK_EVENT_CLEAR && wdata_i[0] && !event_i[2][0];
    endsequence

    // The event returns right after the clear, then a quiet cycle follows; a
    // clear that lingered would wipe the bit again in that quiet cycle.
    sequence s_event_after_clear;
        s_clear_lock0_phase ##1 (!wr_i && event_i[2][0]) ##1 !wr_i;
    endsequence

    a_self_release: assert property ( // [R14]
        @(posedge clk_sys_i) disable iff (rst_i)
        s_event_after_clear |=> monitor_o[2][0])
        else $error("Clear held beyond its write.");

    a_zero_bits_kept: assert property ( // [R15]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::LOOP0_LOCK_EVENT_CLEAR && wdata_i == 8'h01
        && event_i[2] == 8'h00
        |=> monitor_o[2][7:1] == $past(monitor_o[2][7:1]))
        else $error("Zero clear bits disturbed their neighbours.");

    a_other_group_kept: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == iecb_pkg::REF_AB_EVENT_CLEAR && event_i[2] == 8'h00
        |=> monitor_o[2] == $past(monitor_o[2]))
        else $error("Clear write reached another group.");

    a_monitor_readback: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (rst_i)
        rd_i && addr_i == iecb_pkg::EVENT_MONITOR_BASE |=> rdata_o == $past(monitor_o[0]))
        else $error("Monitor read back differs from the latched bits.");

    a_irq_follows: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (rst_i)
        irq_o == |(monitor_o & mask))
        else $error("Interrupt does not track masked monitor.");

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the interrupt event clear bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [11:0] addr; logic [7:0] pat; logic [7:0] exp;} iecb_row_t;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    iecb_pkg::iecb_bank_t event_i = '0;
    iecb_pkg::iecb_bank_t monitor_o;
    logic irq_o;
    iecb_row_t rows [8];
    int fail_count = 0;
    int samples_checked = 0;

    iecb_top uut
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .event_i(event_i),
        .monitor_o(monitor_o),
        .irq_o(irq_o)
    );

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic bus_rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic pulse(input int g, input logic [7:0] v);
        @(posedge clk_sys_i);
        event_i[g] <= v;
        @(posedge clk_sys_i);
        event_i <= '0;
        #1;
    endtask

    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1000000;
        fail_count++;
        $display("MISMATCH at %0t: run did not finish in time", $time);
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rows[0] = '{12'hA07, 8'h0F, 8'h70};
        rows[1] = '{12'hA08, 8'hF0, 8'h07};
        rows[2] = '{12'hA09, 8'h55, 8'hAA};
        rows[3] = '{12'hA0A, 8'hAA, 8'h55};
        rows[4] = '{12'hA0B, 8'h0F, 8'hF0};
        rows[5] = '{12'hA0C, 8'hF0, 8'h0F};
        rows[6] = '{12'hA0D, 8'h81, 8'h7E};
        rows[7] = '{12'hA0E, 8'h18, 8'hE7};
        repeat (6) @(posedge clk_sys_i);
        for (int g = 0; g < 8; g++)
            chk(monitor_o[g], iecb_pkg::MONITOR_RESET);
        chk({7'h00, irq_o}, 8'h00);
        rst_i <= 1'b0;
        $display("test reset_start done");
        for (int g = 0; g < 8; g++)
        begin
            pulse(g, iecb_pkg::FULL_BYTE);
            chk(monitor_o[g], (g < 2) ? iecb_pkg::REF_CLEAR_VALID_BITS : 8'hFF);
            bus_wr(rows[g].addr, rows[g].pat);
            chk(monitor_o[g], rows[g].exp);
            bus_rd(iecb_pkg::EVENT_MONITOR_BASE + 12'(g), rows[g].exp);
            bus_wr(rows[g].addr, iecb_pkg::FULL_BYTE);
            chk(monitor_o[g], 8'h00);
        end
        $display("test clear_table done");
        pulse(2, 8'h01);
        bus_wr(12'hA09, 8'h01);
        chk(monitor_o[2], 8'h00);
        // An event landing with its own clear must survive.
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= 12'hA09;
        wdata_i <= 8'h01;
        event_i[2] <= 8'h01;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        event_i <= '0;
        #1;
        chk(monitor_o[2], 8'h01);
        bus_wr(12'hA09, 8'h00);
        chk(monitor_o[2], 8'h01);
        bus_wr(12'hA09, 8'h01);
        pulse(2, 8'h01);
        chk(monitor_o[2], 8'h01);
        // The event returns in the cycle right after its clear and must stay latched.
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= iecb_pkg::LOOP0_LOCK_EVENT_CLEAR;
        wdata_i <= 8'h01;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        event_i[2] <= 8'h01;
        @(posedge clk_sys_i);
        event_i <= '0;
        @(posedge clk_sys_i);
        #1;
        chk(monitor_o[2], 8'h01);
        $display("test clear_race done");
        bus_wr(iecb_pkg::IRQ_MASK_BASE + 12'h002, 8'h01);
        @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h01);
        bus_rd(iecb_pkg::IRQ_STATUS, 8'h04);
        bus_rd(iecb_pkg::IRQ_MASK_BASE + 12'h002, 8'h01);
        bus_wr(12'hA09, 8'h01);
        @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        pulse(2, 8'h02);
        @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        bus_rd(12'hA09, iecb_pkg::READ_IDLE);
        bus_rd(12'h123, iecb_pkg::READ_IDLE);
        pulse(2, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        $display("test irq done");
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk(monitor_o[2], iecb_pkg::MONITOR_RESET);
        chk({7'h00, irq_o}, 8'h00);
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus_rd(iecb_pkg::IRQ_MASK_BASE + 12'h002, iecb_pkg::MASK_RESET);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
